// ==== hw/bft_pkg.sv ====
// Contract
// - second trip drives its own output
// - current only: phase or residual starts timers
// - current only: second trip after full delay
// - current only: failure after full delay
// - current only: timers reset when current drops
// - current and trip: hold timers until trip
// - current and trip: start on trip with current
// - current and trip: run while both persist
// - current or trip: either one starts timers
// - current or trip: second trip after delay
// - current or trip: reset only when both clear
// - failure timer runs without second trip
// - one shared pickup starts both timers
// - 5 ms steps, defaults 100/200 ms
// - block at pickup blocks, releases running pickup
package bft_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned STEP_NS = 5000000;
  localparam int unsigned STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_W = 21;
  localparam int unsigned DELAY_W = 19;
  localparam logic [DELAY_W-1:0] RETRIP_DELAY_RST = 19'h00014;
  localparam logic [DELAY_W-1:0] FAIL_DELAY_RST = 19'h00028;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_RETRIP_DELAY = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FAIL_DELAY = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_EVENT = 8'h10;

  // control fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_RETRIP_EN_BIT = 3;
  localparam logic CTRL_ENABLE_RST = 1'h1;
  localparam logic CTRL_RETRIP_EN_RST = 1'h1;

  // status fields
  localparam int unsigned ST_PHASE_BIT = 0;
  localparam int unsigned ST_RES_BIT = 1;
  localparam int unsigned ST_TRIP_BIT = 2;
  localparam int unsigned ST_BLOCK_BIT = 3;
  localparam int unsigned ST_PICKUP_BIT = 4;
  localparam int unsigned ST_BLOCKED_BIT = 5;
  localparam int unsigned ST_RETRIP_BIT = 6;
  localparam int unsigned ST_FAIL_BIT = 7;

  // sticky event fields
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_PICKUP_BIT = 0;
  localparam int unsigned EV_BLOCKED_BIT = 1;
  localparam int unsigned EV_RETRIP_BIT = 2;
  localparam int unsigned EV_FAIL_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // criterion and pickup states
  typedef enum logic [1:0] {
    BFT_CRIT_CURRENT = 2'b00,
    BFT_CRIT_CUR_AND_TRIP = 2'b01,
    BFT_CRIT_CUR_OR_TRIP = 2'b10,
    BFT_CRIT_SPARE = 2'b11
  } bft_crit_t;

  typedef enum logic [1:0] {
    BFT_ST_IDLE = 2'b00,
    BFT_ST_RUN = 2'b01,
    BFT_ST_BLOCKED = 2'b10
  } bft_state_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

endpackage : bft_pkg

// ==== hw/bft_delay_timer.sv ====
`timescale 1ns/1ns
module bft_delay_timer
  import bft_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic step_tick,
  input wire logic [DELAY_W-1:0] limit,
  output logic expired
);

  logic [DELAY_W-1:0] steps;

  // step counter, cleared whenever pickup drops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      steps <= '0;
    end else if (!run) begin
      steps <= '0;
    end else if (step_tick && !expired) begin
      steps <= steps + 1'b1;
    end
  end

  // expiry flag, held for as long as run stays high
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      expired <= 1'b0;
    end else if (!run) begin
      expired <= 1'b0;
    end else if (steps >= limit) begin
      expired <= 1'b1;
    end
  end

endmodule : bft_delay_timer

// ==== hw/bft_top.sv ====
`timescale 1ns/1ns
module bft_top
  import bft_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // comparator and supervision pins
  input wire logic phase_over_threshold,
  input wire logic residual_current_threshold,
  input wire logic primary_trip_active,
  input wire logic block_in,
  // command and indication outputs
  output logic second_trip_out,
  output logic breaker_failure_output,
  output logic failure_pickup_flag,
  output logic blocked_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0] phase_sync;
  logic [2:0] res_sync;
  logic [2:0] trip_sync;
  logic [2:0] block_sync;
  logic phase_over;
  logic res_over;
  logic trip_on;
  logic block_on;

  logic ctrl_enable;
  bft_crit_t ctrl_mode;
  logic ctrl_retrip_en;
  logic [DELAY_W-1:0] retrip_delay;
  logic [DELAY_W-1:0] fail_delay;
  logic [EV_W-1:0] event_flags;

  logic dp_write;
  logic [ADDR_W-1:0] dp_addr;
  logic addr_phase;

  bft_state_t state;
  bft_state_t next_state;
  logic current_over;
  logic pickup_cond;
  logic running;
  logic [PRESCALE_W-1:0] prescale;
  logic step_tick;
  logic retrip_expired;
  logic fail_expired;
  logic [EV_W-1:0] event_set;
  logic [EV_W-1:0] event_clr;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // a change counts once the second and third stage agree
  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction : filt

  // read-back value for one register address
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = WORD_ZERO;
    case (a)
      REG_CTRL: begin
        w[CTRL_ENABLE_BIT] = ctrl_enable;
        w[CTRL_MODE_LSB +: 2] = ctrl_mode;
        w[CTRL_RETRIP_EN_BIT] = ctrl_retrip_en;
      end
      REG_RETRIP_DELAY: begin
        w[DELAY_W-1:0] = retrip_delay;
      end
      REG_FAIL_DELAY: begin
        w[DELAY_W-1:0] = fail_delay;
      end
      REG_STATUS: begin
        w[ST_PHASE_BIT] = phase_over;
        w[ST_RES_BIT] = res_over;
        w[ST_TRIP_BIT] = trip_on;
        w[ST_BLOCK_BIT] = block_on;
        w[ST_PICKUP_BIT] = failure_pickup_flag;
        w[ST_BLOCKED_BIT] = blocked_flag;
        w[ST_RETRIP_BIT] = second_trip_out;
        w[ST_FAIL_BIT] = breaker_failure_output;
      end
      REG_EVENT: begin
        w[EV_W-1:0] = event_flags;
      end
      default: begin
        w = WORD_ZERO;
      end
    endcase
    read_word = w;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, three stages each
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_sync <= '0;
      res_sync <= '0;
      trip_sync <= '0;
      block_sync <= '0;
    end else begin
      phase_sync <= {phase_sync[1:0], phase_over_threshold};
      res_sync <= {res_sync[1:0], residual_current_threshold};
      trip_sync <= {trip_sync[1:0], primary_trip_active};
      block_sync <= {block_sync[1:0], block_in};
    end
  end

  // filtered levels, only stages two and three are looked at
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_over <= 1'b0;
      res_over <= 1'b0;
      trip_on <= 1'b0;
      block_on <= 1'b0;
    end else begin
      phase_over <= filt(phase_sync, phase_over);
      res_over <= filt(res_sync, res_over);
      trip_on <= filt(trip_sync, trip_on);
      block_on <= filt(block_sync, block_on);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  // address phase qualifier
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

  // capture address phase of a write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_write <= 1'b0;
      dp_addr <= '0;
    end else begin
      dp_write <= addr_phase && hwrite;
      dp_addr <= haddr;
    end
  end

  // read data registered at the address phase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= WORD_ZERO;
    end else if (addr_phase && !hwrite) begin
      hrdata <= read_word(haddr);
    end else begin
      hrdata <= WORD_ZERO;
    end
  end

  // always ready, always okay
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_enable <= CTRL_ENABLE_RST;
      ctrl_mode <= BFT_CRIT_CURRENT;
      ctrl_retrip_en <= CTRL_RETRIP_EN_RST;
    end else if (dp_write && dp_addr == REG_CTRL) begin
      ctrl_enable <= hwdata[CTRL_ENABLE_BIT];
      ctrl_mode <= bft_crit_t'(hwdata[CTRL_MODE_LSB +: 2]);
      ctrl_retrip_en <= hwdata[CTRL_RETRIP_EN_BIT];
    end
  end

  // delay registers in 5 ms steps
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      retrip_delay <= RETRIP_DELAY_RST;
      fail_delay <= FAIL_DELAY_RST;
    end else if (dp_write) begin
      if (dp_addr == REG_RETRIP_DELAY) begin
        retrip_delay <= hwdata[DELAY_W-1:0];
      end
      if (dp_addr == REG_FAIL_DELAY) begin
        fail_delay <= hwdata[DELAY_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pickup condition per criterion

  // either phase or residual comparator counts as over-current
  assign current_over = phase_over || res_over;

  always_comb begin
    case (ctrl_mode)
      BFT_CRIT_CUR_AND_TRIP: begin
        pickup_cond = current_over && trip_on;
      end
      BFT_CRIT_CUR_OR_TRIP: begin
        pickup_cond = current_over || trip_on;
      end
      BFT_CRIT_CURRENT: begin
        pickup_cond = current_over;
      end
      default: begin
        pickup_cond = current_over;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pickup state machine

  always_comb begin
    next_state = state;
    case (state)
      BFT_ST_IDLE: begin
        if (ctrl_enable && pickup_cond) begin
          next_state = block_on ? BFT_ST_BLOCKED : BFT_ST_RUN;
        end
      end
      BFT_ST_RUN: begin
        if (!ctrl_enable || !pickup_cond) begin
          next_state = BFT_ST_IDLE;
        end else if (block_on) begin
          next_state = BFT_ST_BLOCKED;
        end
      end
      BFT_ST_BLOCKED: begin
        if (!ctrl_enable || !pickup_cond) begin
          next_state = BFT_ST_IDLE;
        end
      end
      default: begin
        next_state = BFT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= BFT_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // one pickup drives both timers
  assign running = (state == BFT_ST_RUN) && (next_state == BFT_ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // shared 5 ms prescaler, restarted at each pickup

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= '0;
    end else if (!running) begin
      prescale <= '0;
    end else if (prescale == PRESCALE_W'(STEP_CYCLES_P - 1)) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  assign step_tick = running && (prescale == PRESCALE_W'(STEP_CYCLES_P - 1));

  ////////////////////////////////////////////////////////////////////////////
  // delay timers

  // second-trip timer
  bft_delay_timer u_retrip_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(running),
    .step_tick(step_tick),
    .limit(retrip_delay),
    .expired(retrip_expired)
  );

  // breaker-failure timer, runs even without second trip
  bft_delay_timer u_fail_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(running),
    .step_tick(step_tick),
    .limit(fail_delay),
    .expired(fail_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command outputs, held while pickup stays

  // second trip on its own contact
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_trip_out <= 1'b0;
    end else begin
      second_trip_out <= ctrl_retrip_en && running && retrip_expired;
    end
  end

  // breaker failure to the incoming feeder
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      breaker_failure_output <= 1'b0;
    end else begin
      breaker_failure_output <= running && fail_expired;
    end
  end

  // pickup and blocked indications
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      failure_pickup_flag <= 1'b0;
      blocked_flag <= 1'b0;
    end else begin
      failure_pickup_flag <= (next_state == BFT_ST_RUN);
      blocked_flag <= (next_state == BFT_ST_BLOCKED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear, set wins

  // rising edges of the indications
  always_comb begin
    event_set = '0;
    event_set[EV_PICKUP_BIT] = (next_state == BFT_ST_RUN) && !failure_pickup_flag;
    event_set[EV_BLOCKED_BIT] = (next_state == BFT_ST_BLOCKED) && !blocked_flag;
    event_set[EV_RETRIP_BIT] = ctrl_retrip_en && running && retrip_expired && !second_trip_out;
    event_set[EV_FAIL_BIT] = running && fail_expired && !breaker_failure_output;
  end

  // clear mask from a write to the event register
  assign event_clr = (dp_write && dp_addr == REG_EVENT) ? hwdata[EV_W-1:0] : '0;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      event_flags <= '0;
    end else begin
      event_flags <= (event_flags & ~event_clr) | event_set;
    end
  end

endmodule : bft_top

// ==== dv/bft_assertions.sv ====
`timescale 1ns/1ns
module bft_checker
  import bft_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic phase_over_threshold,
  input wire logic residual_current_threshold,
  input wire logic primary_trip_active,
  input wire logic block_in,
  input wire logic second_trip_out,
  input wire logic breaker_failure_output,
  input wire logic failure_pickup_flag,
  input wire logic blocked_flag
);
  logic rd_dp;
  // marks the data phase of a taken read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_dp <= 1'b0;
    end else begin
      rd_dp <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // bus side
  a_bus_ready: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_rdata_idle: assert property (!rd_dp |-> hrdata == WORD_ZERO) else $error("hrdata outside read");
  ////////////////////////////////////////////////////////////////////////////
  // supervision side
  a_fail_needs_pickup: assert property (breaker_failure_output |-> failure_pickup_flag)
    else $error("failure without pickup");
  a_retrip_needs_pickup: assert property (second_trip_out |-> failure_pickup_flag)
    else $error("second trip without pickup");
  a_outputs_fall_together: assert property ($fell(failure_pickup_flag) |->
    !breaker_failure_output && !second_trip_out) else $error("outputs outlive pickup");
  a_block_excludes_run: assert property (blocked_flag |-> !failure_pickup_flag &&
    !breaker_failure_output && !second_trip_out) else $error("blocked but running");
  a_quiet_idle: assert property ((!phase_over_threshold && !residual_current_threshold &&
    !primary_trip_active)[*8] |=> !failure_pickup_flag) else $error("pickup without cause");
  a_fail_after_pickup: assert property ($rose(breaker_failure_output) |->
    $past(failure_pickup_flag)) else $error("failure rose before pickup");
endmodule : bft_checker
bind bft_top bft_checker #(.STEP_CYCLES_P(STEP_CYCLES_P)) u_chk (.ref_clk, .rst_b, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .phase_over_threshold,
  .residual_current_threshold, .primary_trip_active, .block_in, .second_trip_out, .breaker_failure_output,
  .failure_pickup_flag, .blocked_flag);

// ==== dv/bft_plant_model.sv ====
`timescale 1ns/1ns
module bft_plant_model #(
  parameter int OPEN_CYCLES = 2
)
(
  input wire logic ref_clk,
  input wire logic phase_fault,
  input wire logic res_fault,
  input wire logic trip_cmd,
  input wire logic coil_ok,
  input wire logic second_trip_out,
  output logic phase_over_threshold,
  output logic residual_current_threshold,
  output logic primary_trip_active
);
  int open_cnt = 0;
  logic cleared = 1'b0;
  // redundant coil opens the breaker some cycles after the second trip
  always_ff @(posedge ref_clk) begin
    if (!phase_fault && !res_fault && !trip_cmd) begin
      cleared <= 1'b0;
      open_cnt <= 0;
    end else if (coil_ok && second_trip_out && !cleared) begin
      open_cnt <= open_cnt + 1;
      cleared <= open_cnt >= OPEN_CYCLES - 1;
    end
  end
  // comparators and primary trip drop once the fault is cleared
  assign phase_over_threshold = phase_fault && !cleared;
  assign residual_current_threshold = res_fault && !cleared;
  assign primary_trip_active = trip_cmd && !cleared;
endmodule : bft_plant_model

// ==== dv/breaker_failure_timing_logic_tb.sv ====
`timescale 1ns/1ns
module breaker_failure_timing_logic_tb
  import bft_pkg::*;
;
  localparam int unsigned SC = 4;
  logic ref_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, block_in = 0;
  logic [ADDR_W-1:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000, hrdata, q;
  logic hready, hreadyout, hresp, second_trip_out, breaker_failure_output, failure_pickup_flag, blocked_flag;
  logic phase_over_threshold, residual_current_threshold, primary_trip_active;
  logic phase_fault = 0, res_fault = 0, trip_cmd = 0, coil_ok = 0;
  logic [3:0] sigs;
  logic [5:0] rows [10] = '{6'h09, 6'h05, 6'h02, 6'h18, 6'h1B, 6'h12, 6'h23, 6'h25, 6'h20, 6'h39};
  int mismatches = 0, check_count = 0, n1, n2;
  assign hready = hreadyout;
  assign sigs = {breaker_failure_output, second_trip_out, failure_pickup_flag, blocked_flag};
  bft_top #(.STEP_CYCLES_P(SC)) uut (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .phase_over_threshold, .residual_current_threshold,
    .primary_trip_active, .block_in, .second_trip_out, .breaker_failure_output, .failure_pickup_flag,
    .blocked_flag);
  bft_plant_model u_plant (.ref_clk, .phase_fault, .res_fault, .trip_cmd, .coil_ok, .second_trip_out,
    .phase_over_threshold, .residual_current_threshold, .primary_trip_active);
  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic pins(input logic p, input logic r, input logic t, input logic b);
    phase_fault <= p;
    res_fault <= r;
    trip_cmd <= t;
    block_in <= b;
  endtask : pins
  task automatic cyc_to(input int k, input int lim, output int n);
    n = 0;
    while (sigs[k] !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : cyc_to
  task automatic settle(input string nm, input logic [3:0] e);
    repeat (12) @(posedge ref_clk);
    chk(nm, {28'h0, e}, {28'h0, sigs});
  endtask : settle
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    bus(0, REG_CTRL, 0); chk("ctrl", 32'h00000009, q);
    bus(0, REG_RETRIP_DELAY, 0); chk("retrip delay", 32'h00000014, q);
    bus(0, REG_FAIL_DELAY, 0); chk("fail delay", 32'h00000028, q);
    bus(0, 8'h20, 0); chk("unmapped", 32'h00000000, q);
    bus(1, REG_RETRIP_DELAY, 32'h00000003);
    bus(1, REG_FAIL_DELAY, 32'h00000006);
    $display("registers done");
    // rows: mode, phase, residual, trip, expected pickup
    for (int i = 0; i < 10; i++) begin
      bus(1, REG_CTRL, {28'h0, 1'b1, rows[i][5:4], 1'b1});
      pins(rows[i][3], rows[i][2], rows[i][1], 1'b0);
      cyc_to(1, 12, n1);
      chk("pickup", {31'h0, rows[i][0]}, {31'h0, sigs[1]});
      if (rows[i][0]) begin
        cyc_to(2, 40, n1);
        cyc_to(3, 40, n2);
        chk_rng("retrip time", 3 * SC, 3 * SC + 5, n1);
        chk_rng("fail time", 6 * SC, 6 * SC + 5, n1 + n2);
        chk("both out", 32'h1, {31'h0, sigs[2] && sigs[3]});
      end else begin
        settle("held", 4'h0);
      end
      pins(0, 0, 0, 0);
      settle("released", 4'h0);
      $display("row %0d done", i);
    end
    // current and trip: losing trip mid run stops timers
    bus(1, REG_CTRL, 32'h0000000B);
    pins(1, 0, 1, 0);
    settle("and run", 4'h2);
    pins(1, 0, 0, 0);
    settle("and drop", 4'h0);
    // current or trip: runs until both clear
    bus(1, REG_CTRL, 32'h0000000D);
    pins(1, 0, 1, 0);
    settle("or run", 4'h2);
    pins(0, 0, 1, 0);
    settle("or one left", 4'h6);
    pins(0, 0, 0, 0);
    settle("or clear", 4'h0);
    $display("criteria drop done");
    // no second trip path: failure alone
    bus(1, REG_CTRL, 32'h00000001);
    pins(1, 0, 0, 0);
    cyc_to(3, 60, n1);
    chk("fail only", 32'h8, {28'h0, sigs & 4'hC});
    pins(0, 0, 0, 0);
    settle("fail only off", 4'h0);
    // block at pickup, then block arriving during a run
    bus(1, REG_CTRL, 32'h00000009);
    pins(1, 0, 0, 1);
    settle("blocked", 4'h1);
    pins(0, 0, 0, 0);
    settle("unblocked", 4'h0);
    pins(1, 0, 0, 0);
    settle("run", 4'h2);
    pins(1, 0, 0, 1);
    settle("late block", 4'h1);
    pins(0, 0, 0, 0);
    settle("block off", 4'h0);
    $display("block done");
    // redundant coil clears the fault before failure
    bus(1, REG_EVENT, 32'h0000000F);
    coil_ok <= 1'b1;
    pins(1, 0, 0, 0);
    repeat (50) @(posedge ref_clk);
    chk("coil cleared", 32'h0, {28'h0, sigs});
    bus(0, REG_EVENT, 0); chk("events", 32'h00000005, q);
    pins(0, 0, 0, 0);
    settle("coil off", 4'h0);
    $display("coil done");
    // reset in mid-run clears outputs and restores defaults
    pins(1, 0, 0, 0);
    repeat (12) @(posedge ref_clk);
    bus(0, REG_STATUS, 0); chk("status", 32'h00000011, q);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    chk("reset outs", 32'h0, {28'h0, sigs});
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    bus(0, REG_RETRIP_DELAY, 0); chk("delay after reset", 32'h00000014, q);
    pins(0, 0, 0, 0);
    settle("reset off", 4'h0);
    $display("reset done");
    close_out();
  end
endmodule : breaker_failure_timing_logic_tb
